// file: thermal_alarm_and_standby.sv
`timescale 1ns/1ps
// Behaviour
// - Local mask bit blocks local alarm
// - Remote 1 mask bit blocks its alarm
// - Remote 2 mask bit blocks its alarm
// - Global mask bit blocks every alarm
// - Configuration read at 0x03, written 0x09
// - Standby stops converter, aborts running conversion
// - Register port keeps working in standby
// - One-shot write converts once in standby
// - One-shot write data is ignored
// - Limit changes re-checked even in standby
// - Open diode sampled at conversion start
// - Open flag asserts alarm in alarm mode
// - Faulty remote keeps last good result
// - Alarm on high exceeded or low reached
// - Alarm released after response, clear, quiet
// - Overtemp output unmaskable on limit exceeded
// - Overtemp releases at limit minus hysteresis
// - Power-on limits 85, hysteresis 10
// - Hysteresis counts whole degrees unsigned
// - One hysteresis serves local and remote
// - Shared pin can be second overtemp
// - Second overtemp uses the same hysteresis
// - Alert response answers own seven-bit address
module thermal_alarm_and_standby #(
    parameter int         CONV_GAP = thermal_alarm_pkg::CONV_INTERVAL_CYC,
    parameter logic [6:0] DEV_ADDR = 7'h4C  // Arbitrary default address.
) (
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic       linkClk,
    input  wire logic       busWr,
    input  wire logic       busRd,
    input  wire logic       busAra,
    input  wire logic [7:0] busPtr,
    input  wire logic [7:0] busWrData,
    output logic      [7:0] busRdData,
    output logic            busRdValid,
    output logic            busAraHit,
    output logic            busBusy,
    input  wire logic       convDone,
    input  wire logic [7:0] convLocal,
    input  wire logic [7:0] convRemote1,
    input  wire logic [7:0] convRemote2,
    input  wire logic       openCmp1,
    input  wire logic       openCmp2,
    input  wire logic [7:0] highLimit [3],
    input  wire logic [7:0] lowLimit  [3],
    output logic            convStart,
    output logic            convAbort,
    output logic            overtempOut,
    output logic            overtempOe,
    output logic            sharedPinOut,
    output logic            sharedPinOe
);

    // Next state of a hysteresis latch: set above limit, clear at limit-hyst.
    function automatic logic hystStep(input logic l, input logic [7:0] t,
                                      input logic [7:0] lim,
                                      input logic [7:0] hy);
        logic signed [8:0] rel;
        rel = $signed({lim[7], lim}) - $signed({1'b0, hy});
        if ($signed(t) > $signed(lim))
            return 1'b1;
        else if ($signed({t[7], t}) <= rel)
            return 1'b0;
        else
            return l;
    endfunction : hystStep

    // Link-domain request capture, held stable until the answer returns.
    logic       reqTgl_r;
    logic [1:0] reqKind_r;
    logic [7:0] reqPtr_r;
    logic [7:0] reqData_r;
    logic       rspSync1_r, rspSync2_r, rspSeen_r;
    logic       rspTgl_r;
    logic [7:0] rspData_r;
    logic       rspHit_r;
    logic       rspEdge;

    assign rspEdge = rspSync2_r ^ rspSeen_r;

    // Answer toggle crosses into the link domain through two flip-flops.
    always_ff @(posedge linkClk or negedge rst_n) begin
        if (!rst_n) begin
            rspSync1_r <= 1'b0;
            rspSync2_r <= 1'b0;
            rspSeen_r  <= 1'b0;
        end else begin
            rspSync1_r <= rspTgl_r;
            rspSync2_r <= rspSync1_r;
            rspSeen_r  <= rspSync2_r;
        end
    end

    // One request at a time; the port works in every mode.
    always_ff @(posedge linkClk or negedge rst_n) begin
        if (!rst_n) begin
            reqTgl_r   <= 1'b0;
            reqKind_r  <= thermal_alarm_pkg::REQ_WRITE;
            reqPtr_r   <= 8'h00;
            reqData_r  <= 8'h00;
            busBusy    <= 1'b0;
            busRdData  <= 8'h00;
            busRdValid <= 1'b0;
            busAraHit  <= 1'b0;
        end else begin
            busRdValid <= 1'b0;
            if (!busBusy && (busWr || busRd || busAra)) begin
                reqTgl_r  <= ~reqTgl_r;
                reqPtr_r  <= busPtr;
                reqData_r <= busWrData;
                busBusy   <= 1'b1;
                if (busAra)
                    reqKind_r <= thermal_alarm_pkg::REQ_ARA;
                else if (busRd)
                    reqKind_r <= thermal_alarm_pkg::REQ_READ;
                else
                    reqKind_r <= thermal_alarm_pkg::REQ_WRITE;
            end else if (busBusy && rspEdge) begin
                busBusy <= 1'b0;
                if (reqKind_r != thermal_alarm_pkg::REQ_WRITE) begin
                    busRdData  <= rspData_r;
                    busAraHit  <= rspHit_r;
                    busRdValid <= 1'b1;
                end
            end
        end
    end

    // Request toggle crosses into the core domain.
    logic reqSync1_r, reqSync2_r, reqSeen_r;
    logic reqEv, wrEv, rdEv, araEv;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            reqSync1_r <= 1'b0;
            reqSync2_r <= 1'b0;
            reqSeen_r  <= 1'b0;
        end else begin
            reqSync1_r <= reqTgl_r;
            reqSync2_r <= reqSync1_r;
            reqSeen_r  <= reqSync2_r;
        end
    end

    // Decode of the request that has just arrived.
    assign reqEv = reqSync2_r ^ reqSeen_r;
    assign wrEv  = reqEv && reqKind_r == thermal_alarm_pkg::REQ_WRITE;
    assign rdEv  = reqEv && reqKind_r == thermal_alarm_pkg::REQ_READ;
    assign araEv = reqEv && reqKind_r == thermal_alarm_pkg::REQ_ARA;

    // Programmable registers; configuration written only at its write view.
    logic [7:0] cfg_r, rpt_r, thermLoc_r, thermRem_r, hyst_r;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_r      <= thermal_alarm_pkg::CONFIG_RST;
            rpt_r      <= thermal_alarm_pkg::REPEAT_RST;
            thermLoc_r <= thermal_alarm_pkg::OVERTEMP_OUT_N_LIMIT_RST;
            thermRem_r <= thermal_alarm_pkg::OVERTEMP_OUT_N_LIMIT_RST;
            hyst_r     <= thermal_alarm_pkg::HYST_RST;
        end else if (wrEv) begin
            unique case (reqPtr_r)
                thermal_alarm_pkg::PTR_CONFIG_WRITE: cfg_r <= reqData_r;
                thermal_alarm_pkg::PTR_REPEAT_MASK:  rpt_r <= reqData_r;
                thermal_alarm_pkg::PTR_OVERTEMP_OUT_N_LOCAL:  thermLoc_r <= reqData_r;
                thermal_alarm_pkg::PTR_OVERTEMP_OUT_N_REMOTE: thermRem_r <= reqData_r;
                thermal_alarm_pkg::PTR_HYST:         hyst_r <= reqData_r;
                default: ;
            endcase
        end
    end

    logic standby, pinSel, oneShotEv;
    assign standby   = cfg_r[thermal_alarm_pkg::CFG_STANDBY];
    assign pinSel    = cfg_r[thermal_alarm_pkg::CFG_PIN_SEL];
    // Only the write event matters; the data byte is dropped.
    assign oneShotEv = wrEv && reqPtr_r == thermal_alarm_pkg::PTR_ONE_SHOT;

    // Open-diode comparators are asynchronous and pass two flip-flops.
    logic [1:0] openSync1_r, openSync2_r;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            openSync1_r <= 2'b00;
            openSync2_r <= 2'b00;
        end else begin
            openSync1_r <= {openCmp2, openCmp1};
            openSync2_r <= openSync1_r;
        end
    end

    // Conversion sequencer: periodic in monitor mode, one-shot in standby.
    thermal_alarm_pkg::conv_state_t convSt_r;
    logic [23:0] gap_r;
    logic        shot_r;
    logic [1:0]  openSeen_r;
    logic        startNow, abortNow, doneNow;

    assign startNow = convSt_r == thermal_alarm_pkg::CONV_IDLE &&
                      ((!standby && gap_r == 24'h00_0000) ||
                       (standby && oneShotEv));
    assign abortNow = convSt_r == thermal_alarm_pkg::CONV_BUSY &&
                      standby && !shot_r;
    assign doneNow  = convSt_r == thermal_alarm_pkg::CONV_BUSY &&
                      convDone && !abortNow;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            convSt_r   <= thermal_alarm_pkg::CONV_IDLE;
            shot_r     <= 1'b0;
            convStart  <= 1'b0;
            convAbort  <= 1'b0;
            openSeen_r <= 2'b00;
        end else begin
            convStart <= startNow;
            convAbort <= abortNow;
            if (startNow) begin
                convSt_r   <= thermal_alarm_pkg::CONV_BUSY;
                shot_r     <= standby;
                openSeen_r <= openSync2_r;
            end else if (abortNow || doneNow) begin
                convSt_r <= thermal_alarm_pkg::CONV_IDLE;
                shot_r   <= 1'b0;
            end
        end
    end

    // Idle gap between automatic conversions; held loaded in standby.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            gap_r <= 24'(CONV_GAP);
        else if (standby || convSt_r == thermal_alarm_pkg::CONV_BUSY)
            gap_r <= 24'(CONV_GAP);
        else if (gap_r != 24'h00_0000)
            gap_r <= gap_r - 24'h00_0001;
    end

    // Result store; an aborted conversion writes nothing.
    logic [7:0] temp_r [3];

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            temp_r[0] <= 8'h00;
            temp_r[1] <= 8'h00;
            temp_r[2] <= 8'h00;
        end else if (doneNow) begin
            temp_r[0] <= convLocal;
            if (!openSeen_r[0])
                temp_r[1] <= convRemote1;
            if (!openSeen_r[1])
                temp_r[2] <= convRemote2;
        end
    end

    // Stored values checked every cycle, so new limits act in standby too.
    logic [2:0] hiV, loV;
    for (genvar i = 0; i < 3; i++) begin : g_cmp
        assign hiV[i] = $signed(temp_r[i]) > $signed(highLimit[i]);
        assign loV[i] = $signed(temp_r[i]) <= $signed(lowLimit[i]);
    end

    // Sticky status bits, cleared by reading; a set in the same cycle wins.
    logic [7:0] st1_r, st2_r, st1Set, st2Set, st1Clr, st2Clr;
    logic [1:0] openSet;

    assign openSet = startNow ? openSync2_r : 2'b00;
    assign st1Set  = {1'b0, hiV[0], loV[0], hiV[1], loV[1], openSet[0],
                      2'b00};
    assign st2Set  = {3'b000, hiV[2], loV[2], openSet[1], 2'b00};
    assign st1Clr  = (rdEv &&
                      reqPtr_r == thermal_alarm_pkg::PTR_STATUS_FIRST) ?
                     8'hFF : 8'h00;
    assign st2Clr  = (rdEv &&
                      reqPtr_r == thermal_alarm_pkg::PTR_STATUS_SECOND) ?
                     8'hFF : 8'h00;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st1_r <= thermal_alarm_pkg::STATUS_RST;
            st2_r <= thermal_alarm_pkg::STATUS_RST;
        end else begin
            st1_r <= (st1_r & ~st1Clr) | st1Set;
            st2_r <= (st2_r & ~st2Clr) | st2Set;
        end
    end

    // Per-channel alarm gates and sources.
    logic [2:0] gate, src, live;
    assign gate[0] = !cfg_r[thermal_alarm_pkg::CFG_ALL_MASK] &&
                     !rpt_r[thermal_alarm_pkg::RPT_LOCAL_MASK];
    assign gate[1] = !cfg_r[thermal_alarm_pkg::CFG_ALL_MASK] &&
                     !cfg_r[thermal_alarm_pkg::CFG_REM1_MASK];
    assign gate[2] = !cfg_r[thermal_alarm_pkg::CFG_ALL_MASK] &&
                     !cfg_r[thermal_alarm_pkg::CFG_REM2_MASK];
    assign src[0]  = st1_r[thermal_alarm_pkg::ST1_LOCAL_HIGH] |
                     st1_r[thermal_alarm_pkg::ST1_LOCAL_LOW];
    assign src[1]  = st1_r[thermal_alarm_pkg::ST_REM_HIGH] |
                     st1_r[thermal_alarm_pkg::ST_REM_LOW] |
                     st1_r[thermal_alarm_pkg::ST_OPEN];
    assign src[2]  = st2_r[thermal_alarm_pkg::ST_REM_HIGH] |
                     st2_r[thermal_alarm_pkg::ST_REM_LOW] |
                     st2_r[thermal_alarm_pkg::ST_OPEN];
    assign live    = (hiV | loV | {openSeen_r, 1'b0}) & gate;

    // Alarm latch: set by an unmasked source, freed only after servicing.
    logic alarm_r, araDone_r, alarmSrc, alarmFree;
    assign alarmSrc  = |(src & gate);
    assign alarmFree = araDone_r && !alarmSrc && !(|live);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            alarm_r   <= 1'b0;
            araDone_r <= 1'b0;
        end else if (!alarm_r) begin
            alarm_r   <= alarmSrc;
            araDone_r <= 1'b0;
        end else if (alarmFree) begin
            alarm_r   <= 1'b0;
            araDone_r <= 1'b0;
        end else if (araEv && !pinSel) begin
            araDone_r <= 1'b1;
        end
    end

    // Read data and alert-response answer back to the link.
    logic [7:0] rdMux;
    always_comb begin
        unique case (reqPtr_r)
            thermal_alarm_pkg::PTR_STATUS_FIRST:  rdMux = st1_r;
            thermal_alarm_pkg::PTR_CONFIG_READ:   rdMux = cfg_r;
            thermal_alarm_pkg::PTR_REPEAT_MASK:   rdMux = rpt_r;
            thermal_alarm_pkg::PTR_STATUS_SECOND: rdMux = st2_r;
            thermal_alarm_pkg::PTR_OVERTEMP_OUT_N_LOCAL:   rdMux = thermLoc_r;
            thermal_alarm_pkg::PTR_OVERTEMP_OUT_N_REMOTE:  rdMux = thermRem_r;
            thermal_alarm_pkg::PTR_HYST:          rdMux = hyst_r;
            default:                  rdMux = thermal_alarm_pkg::READ_NONE;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rspTgl_r  <= 1'b0;
            rspData_r <= 8'h00;
            rspHit_r  <= 1'b0;
        end else if (reqEv) begin
            rspTgl_r <= ~rspTgl_r;
            if (araEv) begin
                rspHit_r  <= alarm_r && !pinSel;
                rspData_r <= (alarm_r && !pinSel) ? {DEV_ADDR, 1'b1} :
                             thermal_alarm_pkg::ARA_NONE;
            end else begin
                rspHit_r  <= 1'b0;
                rspData_r <= rdMux;
            end
        end
    end

    // Hysteresis latches for both overtemp outputs, all channels.
    logic [2:0] overtemp_out_n_r, second_overtemp_out_n_r;
    for (genvar i = 0; i < 3; i++) begin : g_overtemp_out_n
        always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
                overtemp_out_n_r[i]  <= 1'b0;
                second_overtemp_out_n_r[i] <= 1'b0;
            end else begin
                overtemp_out_n_r[i]  <= hystStep(overtemp_out_n_r[i], temp_r[i],
                               (i == 0) ? thermLoc_r : thermRem_r,
                               hyst_r);
                second_overtemp_out_n_r[i] <= hystStep(second_overtemp_out_n_r[i], temp_r[i],
                               highLimit[i], hyst_r);
            end
        end
    end

    // Open-drain pin drivers: enable high pulls the pin low.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            overtempOut  <= 1'b0;
            overtempOe   <= 1'b0;
            sharedPinOut <= 1'b0;
            sharedPinOe  <= 1'b0;
        end else begin
            overtempOut  <= 1'b0;
            sharedPinOut <= 1'b0;
            overtempOe   <= |overtemp_out_n_r;
            sharedPinOe  <= pinSel ? |second_overtemp_out_n_r : alarm_r;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence s_abortStep;
        convSt_r == thermal_alarm_pkg::CONV_BUSY && standby && !shot_r;
    endsequence
    sequence s_idleAfter;
        convAbort && convSt_r == thermal_alarm_pkg::CONV_IDLE;
    endsequence

    property p_localMask;
        rpt_r[thermal_alarm_pkg::RPT_LOCAL_MASK] && !alarm_r &&
        !(gate[1] && src[1]) && !(gate[2] && src[2]) |=> !alarm_r;
    endproperty
    a_localMask: assert property (p_localMask)
        else $error("Masked local channel raised the alarm.");

    property p_rem1Mask;
        cfg_r[thermal_alarm_pkg::CFG_REM1_MASK] && !alarm_r &&
        !(gate[0] && src[0]) && !(gate[2] && src[2]) |=> !alarm_r;
    endproperty
    a_rem1Mask: assert property (p_rem1Mask)
        else $error("Masked remote 1 channel raised the alarm.");

    property p_rem2Mask;
        cfg_r[thermal_alarm_pkg::CFG_REM2_MASK] && !alarm_r &&
        !(gate[0] && src[0]) && !(gate[1] && src[1]) |=> !alarm_r;
    endproperty
    a_rem2Mask: assert property (p_rem2Mask)
        else $error("Masked remote 2 channel raised the alarm.");

    property p_allMask;
        cfg_r[thermal_alarm_pkg::CFG_ALL_MASK] && !alarm_r |=> !alarm_r;
    endproperty
    a_allMask: assert property (p_allMask)
        else $error("Global mask failed to hold the alarm off.");

    property p_abort;
        s_abortStep |=> s_idleAfter;
    endproperty
    a_abort: assert property (p_abort)
        else $error("Standby did not abort the running conversion.");

    property p_oneShot;
        standby && oneShotEv && convSt_r == thermal_alarm_pkg::CONV_IDLE
        |=> convStart ##0 convSt_r == thermal_alarm_pkg::CONV_BUSY;
    endproperty
    a_oneShot: assert property (p_oneShot)
        else $error("One-shot write did not start a conversion.");

    property p_openFlag;
        startNow && openSync2_r[0]
        |=> st1_r[thermal_alarm_pkg::ST_OPEN] ##1 alarm_r || !gate[1];
    endproperty
    a_openFlag: assert property (p_openFlag)
        else $error("Open diode on remote 1 not flagged.");

    property p_keepGood;
        doneNow && openSeen_r[0] |=> temp_r[1] == $past(temp_r[1]);
    endproperty
    a_keepGood: assert property (p_keepGood)
        else $error("Faulty remote 1 reading overwrote the result.");

    property p_release;
        $fell(alarm_r) |-> $past(araDone_r) && !$past(alarmSrc);
    endproperty
    a_release: assert property (p_release)
        else $error("Alarm released without being serviced.");

    property p_overtemp_out_n;
        $signed(temp_r[0]) > $signed(thermLoc_r) |=> ##1 overtempOe;
    endproperty
    a_overtemp_out_n: assert property (p_overtemp_out_n)
        else $error("Overtemp output missed a local excursion.");

endmodule : thermal_alarm_and_standby

// file: thermal_alarm_pkg.sv
package thermal_alarm_pkg;

    // Register pointer values seen on the serial register port.
    localparam logic [7:0] PTR_STATUS_FIRST  = 8'h02;
    localparam logic [7:0] PTR_CONFIG_READ   = 8'h03;
    localparam logic [7:0] PTR_CONFIG_WRITE  = 8'h09;
    localparam logic [7:0] PTR_ONE_SHOT      = 8'h0F;
    localparam logic [7:0] PTR_REPEAT_MASK   = 8'h22;
    localparam logic [7:0] PTR_STATUS_SECOND = 8'h23;
    localparam logic [7:0] PTR_OVERTEMP_OUT_N_LOCAL   = 8'h40;
    localparam logic [7:0] PTR_OVERTEMP_OUT_N_REMOTE  = 8'h41;
    localparam logic [7:0] PTR_HYST          = 8'h42;

    // Field positions in the configuration and mask registers.
    localparam int CFG_ALL_MASK    = 7;
    localparam int CFG_STANDBY     = 6;
    localparam int CFG_PIN_SEL     = 5;
    localparam int CFG_REM1_MASK   = 1;
    localparam int CFG_REM2_MASK   = 0;
    localparam int RPT_LOCAL_MASK  = 5;

    // Field positions in the two status registers.
    localparam int ST1_LOCAL_HIGH  = 6;
    localparam int ST1_LOCAL_LOW   = 5;
    localparam int ST_REM_HIGH     = 4;
    localparam int ST_REM_LOW      = 3;
    localparam int ST_OPEN         = 2;

    // Reset values, unmapped-read data and the no-alert answer.
    localparam logic [7:0] CONFIG_RST      = 8'h00;
    localparam logic [7:0] REPEAT_RST      = 8'h00;
    localparam logic [7:0] STATUS_RST      = 8'h00;
    localparam logic [7:0] OVERTEMP_OUT_N_LIMIT_RST = 8'h55;
    localparam logic [7:0] HYST_RST        = 8'h0A;
    localparam logic [7:0] READ_NONE       = 8'h00;
    localparam logic [7:0] ARA_NONE        = 8'hFF;

    // Timing: idle time between automatic conversions.
    localparam int CLK_PERIOD_NS    = 4;
    localparam int CONV_INTERVAL_US = 62500;
    localparam int CONV_INTERVAL_CYC =
        CONV_INTERVAL_US * 1000 / CLK_PERIOD_NS;

    // Kinds of request arriving from the serial engine.
    typedef enum logic [1:0] {
        REQ_WRITE = 2'b00,
        REQ_READ  = 2'b01,
        REQ_ARA   = 2'b11
    } req_kind_t;

    // Conversion sequencer states.
    typedef enum logic [0:0] {
        CONV_IDLE = 1'b0,
        CONV_BUSY = 1'b1
    } conv_state_t;

endpackage : thermal_alarm_pkg

// file: thermal_front_model.sv
`timescale 1ns/1ps
// Conversion front end: answers each start after a short or long delay.
module thermal_front_model (
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic       convStart,
    input  wire logic       convAbort,
    input  wire logic       slowMode,
    input  wire logic [7:0] tempIn [3],
    output logic            convDone,
    output logic      [7:0] convLocal,
    output logic      [7:0] convRemote1,
    output logic      [7:0] convRemote2
);
    int cnt;

    // Results are only valid with the done pulse; otherwise they wander.
    assign convLocal   = convDone ? tempIn[0] : ~tempIn[0];
    assign convRemote1 = convDone ? tempIn[1] : ~tempIn[1];
    assign convRemote2 = convDone ? tempIn[2] : ~tempIn[2];

    // Delay counter; an abort drops the conversion without a result.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 0;
            convDone <= 1'b0;
        end else begin
            convDone <= (cnt == 1) && !convAbort;
            if (convAbort || cnt == 1)
                cnt <= 0;
            else if (convStart)
                cnt <= slowMode ? 12 : 3;
            else if (cnt > 1)
                cnt <= cnt - 1;
        end
    end
endmodule : thermal_front_model

// file: thermal_alarm_and_standby_test.sv
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
    error_cnt++; $display("BAD %0t got %h want %h", $time, a, e); end end
module thermal_alarm_and_standby_test;
    logic       mclk = 1'b0;
    logic       linkClk = 1'b0;
    logic       rst_n = 1'b0;
    logic       busWr = 1'b0;
    logic       busRd = 1'b0;
    logic       busAra = 1'b0;
    logic       slowMode = 1'b0;
    logic       openCmp = 1'b0;
    logic [7:0] busPtr = 8'h00;
    logic [7:0] busWrData = 8'h00;
    logic [7:0] busRdData, convLocal, convRemote1, convRemote2, want;
    logic       busRdValid, busAraHit, busBusy, convDone, convStart;
    logic       convAbort, overtempOut, overtempOe, sharedPinOut, sharedPinOe;
    logic [7:0] temp [3];
    logic [7:0] hiLim [3];
    logic [7:0] loLim [3];
    logic [7:0] expQ [$];
    int         error_cnt = 0;
    int         samples_checked = 0;
    int         starts = 0;

    // Two unrelated clocks.
    always #2 mclk = ~mclk;
    always #7.5 linkClk = ~linkClk;

    thermal_alarm_and_standby #(.CONV_GAP(20), .DEV_ADDR(7'h4C))
        thermal_alarm_and_standby_inst (.mclk(mclk), .rst_n(rst_n),
        .linkClk(linkClk), .busWr(busWr), .busRd(busRd), .busAra(busAra),
        .busPtr(busPtr), .busWrData(busWrData), .busRdData(busRdData),
        .busRdValid(busRdValid), .busAraHit(busAraHit), .busBusy(busBusy),
        .convDone(convDone), .convLocal(convLocal),
        .convRemote1(convRemote1), .convRemote2(convRemote2),
        .openCmp1(openCmp), .openCmp2(openCmp), .highLimit(hiLim),
        .lowLimit(loLim), .convStart(convStart), .convAbort(convAbort),
        .overtempOut(overtempOut), .overtempOe(overtempOe),
        .sharedPinOut(sharedPinOut), .sharedPinOe(sharedPinOe));

    thermal_front_model thermal_front_model_inst (.mclk(mclk),
        .rst_n(rst_n), .convStart(convStart), .convAbort(convAbort),
        .slowMode(slowMode), .tempIn(temp), .convDone(convDone),
        .convLocal(convLocal), .convRemote1(convRemote1),
        .convRemote2(convRemote2));

    // Takes the oldest expected answer whenever the port answers.
    always @(negedge linkClk) begin
        if (busRdValid === 1'b1) begin
            want = expQ.size() ? expQ.pop_front() : 8'hxx;
            `CHK(busRdData, want)
        end
    end

    // Counts conversion starts.
    always @(negedge mclk) begin
        if (convStart === 1'b1)
            starts++;
    end

    // One request: 0 write, 1 read, 2 alert query; waits for busy to drop.
    task automatic req(input int k, input logic [7:0] p, input logic [7:0] d);
        int n;
        n = 0;
        @(negedge linkClk);
        busWr = (k == 0);
        busRd = (k == 1);
        busAra = (k == 2);
        busPtr = p;
        busWrData = d;
        @(negedge linkClk);
        busWr = 1'b0;
        busRd = 1'b0;
        busAra = 1'b0;
        while (busBusy !== 1'b0 && n < 40) begin
            @(negedge linkClk);
            n++;
        end
        `CHK(n < 40, 1'b1)
    endtask : req

    task automatic rd(input int k, input logic [7:0] p, input logic [7:0] e);
        expQ.push_back(e);
        req(k, p, 8'h00);
    endtask : rd

    task automatic mwait(input int n);
        repeat (n) @(negedge mclk);
    endtask : mwait

    task automatic summarize;
        $display("Checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : summarize

    // Watchdog against a hung handshake.
    initial begin
        #200000;
        error_cnt++;
        $display("BAD %0t timeout", $time);
        summarize;
    end

    // Main sequence.
    initial begin
        for (int i = 0; i < 3; i++) begin
            temp[i] = 8'h14;
            hiLim[i] = 8'h7F;
            loLim[i] = 8'h80;
        end
        void'($urandom(54032));
        repeat (4) @(negedge linkClk);
        rst_n = 1'b1;
        repeat (3) @(negedge linkClk);
        rd(1, 8'h03, 8'h00);
        rd(1, 8'h22, 8'h00);
        rd(1, 8'h40, 8'h55);
        rd(1, 8'h42, 8'h0A);
        rd(1, 8'h09, 8'h00);
        req(0, 8'h09, 8'h80);
        rd(1, 8'h03, 8'h80);
        mwait(1);
        hiLim[0] = 8'h50;
        temp[0] = 8'h56;
        mwait(80);
        `CHK(sharedPinOe, 1'b0)
        `CHK(overtempOe, 1'b1)
        `CHK(overtempOut | sharedPinOut, 1'b0)
        req(0, 8'h22, 8'h20);
        req(0, 8'h09, 8'h00);
        mwait(10);
        `CHK(sharedPinOe, 1'b0)
        req(0, 8'h22, 8'h00);
        mwait(10);
        `CHK(sharedPinOe, 1'b1)
        temp[0] = 8'h4C;
        mwait(80);
        `CHK(overtempOe, 1'b1)
        temp[0] = 8'h4B;
        mwait(80);
        `CHK(overtempOe, 1'b0)
        temp[0] = 8'h14;
        mwait(80);
        rd(1, 8'h02, 8'h40);
        rd(2, 8'h00, 8'h99);
        `CHK(busAraHit, 1'b1)
        mwait(10);
        `CHK(sharedPinOe, 1'b0)
        rd(2, 8'h00, 8'hFF);
        `CHK(busAraHit, 1'b0)
        openCmp = 1'b1;
        temp[1] = 8'h30;
        mwait(80);
        `CHK(sharedPinOe, 1'b1)
        openCmp = 1'b0;
        temp[1] = 8'h14;
        mwait(80);
        rd(1, 8'h02, 8'h04);
        rd(1, 8'h23, 8'h04);
        rd(2, 8'h00, 8'h99);
        req(0, 8'h09, 8'h03);
        mwait(1);
        hiLim[1] = 8'h10;
        hiLim[2] = 8'h10;
        mwait(80);
        `CHK(sharedPinOe, 1'b0)
        hiLim[1] = 8'h7F;
        hiLim[2] = 8'h7F;
        rd(1, 8'h02, 8'h10);
        rd(1, 8'h23, 8'h10);
        slowMode = 1'b1;
        req(0, 8'h09, 8'h40);
        rd(1, 8'h03, 8'h40);
        starts = 0;
        mwait(100);
        `CHK(starts, 0)
        req(0, 8'h0F, 8'($urandom));
        mwait(60);
        `CHK(starts, 1)
        loLim[0] = 8'h14;
        mwait(10);
        `CHK(sharedPinOe, 1'b1)
        loLim[0] = 8'h80;
        req(0, 8'h09, 8'h20);
        mwait(1);
        hiLim[0] = 8'h10;
        mwait(80);
        `CHK(sharedPinOe, 1'b1)
        hiLim[0] = 8'h1D;
        mwait(80);
        `CHK(sharedPinOe, 1'b1)
        hiLim[0] = 8'h1E;
        mwait(80);
        `CHK(sharedPinOe, 1'b0)
        summarize;
    end
endmodule : thermal_alarm_and_standby_test
